// ===== core/rts_rx_timeout_supervisor.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module rts_rx_timeout_supervisor #(
  parameter int PRE_W = 8,   // Prescale width
  parameter int CNT_W = 8    // Count width
) (
  // Clock and synchronous reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Register bus, write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data and response
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Receive quality indicators, asynchronous levels
  input  wire logic        carrier_sense_valid,
  input  wire logic        sync_quality_indicator,
  input  wire logic        preamble_quality_indicator,
  // Packet end from the packet handler, asynchronous
  input  wire logic        packet_received,
  // Receive state and outcome events
  output logic             rx_active,
  output logic             rx_data_ready,
  output logic             packet_discard
);
  import rts_pkg::*;

  // Refuse widths that the 16-bit register fields cannot hold
  if (PRE_W < 1 || PRE_W > 16 || CNT_W < 1 || CNT_W > 16) begin : g_bad_width
    $error("rts: widths must be 1 to 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Whole state of the block
  typedef struct packed {
    // Register bus holding stage
    logic             aw_got;      // Write address held
    logic             w_got;       // Write data held
    logic [7:0]       aw_addr;     // Held write address
    logic [31:0]      w_data;      // Held write data
    logic [3:0]       w_strb;      // Held write strobes
    logic             bvalid;      // Write response pending
    logic [1:0]       bresp;       // Write response code
    logic             rvalid;      // Read data pending
    logic [1:0]       rresp;       // Read response code
    logic [31:0]      rdata;       // Read data
    // Configuration registers
    logic [PRE_W-1:0] prescale;    // Prescale value
    logic [CNT_W-1:0] count;       // Count value
    logic [3:0]       stopcfg;     // Select and masks
    // Pin synchronisers
    logic [2:0]       sync1;       // First synchroniser stage
    logic [2:0]       sync2;       // Second synchroniser stage
    logic             pkt1;        // Packet end, first stage
    logic             pkt2;        // Packet end, second stage
    // Timer and outcome
    rts_state_t       state;       // Idle or receiving
    logic [PRE_W-1:0] pre_cnt;     // Prescale divider
    logic [CNT_W-1:0] cnt;         // Timeout countdown
    logic             frozen;      // Stop condition seen, or never-expire mode
    logic             expired;     // Sticky status
    logic             aborted;     // Sticky status
    logic             ready_seen;  // Sticky status
    logic             ready_pulse;
    logic             discard_pulse;
  } rts_regs_t;

  rts_regs_t r;       // Registered state
  rts_regs_t next_r;  // Next state

  logic        stop_cond;   // Combined stop condition
  logic [2:0]  masks;       // Mask bits
  logic [2:0]  ind;         // Synchronised indicators
  logic        wr_go;       // Write both halves present
  logic        tick;        // Prescaled tick
  logic        cmd_start;   // Start strobe from a command write
  logic        cmd_abort;   // Abort strobe from a command write
  logic [31:0] rd_val;      // Read data for the accepted address
  logic        rd_ok;       // Read address is mapped

  // Handshake outputs; a half is refused while held or while a response waits
  assign s_axi_awready = ~r.aw_got & ~r.bvalid;
  assign s_axi_wready  = ~r.w_got & ~r.bvalid;
  assign s_axi_arready = ~r.rvalid;
  // Responses and read data come straight from flops
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rresp   = r.rresp;
  assign s_axi_rdata   = r.rdata;
  // Receive state and one-cycle outcome events
  assign rx_active      = (r.state == RTS_RX);
  assign rx_data_ready  = r.ready_pulse;
  assign packet_discard = r.discard_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Stop condition: single mask selects one indicator, else AND or OR
  always_comb begin
    masks = {r.stopcfg[RTS_CFG_PQ_MASK], r.stopcfg[RTS_CFG_SQ_MASK],
             r.stopcfg[RTS_CFG_CS_MASK]};
    // Indicators arrive two cycles late through the synchroniser
    ind   = r.sync2;
    if (masks == 3'b000) begin
      // No indicator selected: stop condition stays low; AND select freezes the timer below
      stop_cond = 1'b0;
    end else if (r.stopcfg[RTS_CFG_AND_OR]) begin
      // OR: any selected indicator stops
      stop_cond = |(ind & masks);
    end else begin
      // AND: unselected indicators count as true, so one mask acts alone
      stop_cond = &(ind | ~masks);
    end
  end

  // Register read mux
  // Decoded while the address is accepted; unmapped answers an error
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      RTS_OFF_PRESCALE: rd_val[PRE_W-1:0] = r.prescale;
      RTS_OFF_COUNT:    rd_val[CNT_W-1:0] = r.count;
      RTS_OFF_STOPCFG:  rd_val[3:0] = r.stopcfg;
      RTS_OFF_STATUS: begin
        // Live state and sticky outcome flags
        rd_val[RTS_ST_IN_RX]   = (r.state == RTS_RX);
        rd_val[RTS_ST_FROZEN]  = r.frozen;
        rd_val[RTS_ST_EXPIRED] = r.expired;
        rd_val[RTS_ST_DISCARD] = r.expired;
        rd_val[RTS_ST_READY]   = r.ready_seen;
        rd_val[RTS_ST_ABORTED] = r.aborted;
      end
      RTS_OFF_COMMAND:  rd_val = 32'h0000_0000;
      default:          rd_ok = 1'b0;   // Unmapped address
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_r = r;
    // Event pulses last one cycle unless set again below
    next_r.ready_pulse   = 1'b0;
    next_r.discard_pulse = 1'b0;
    // Command strobes live for the cycle in which a write completes
    cmd_start = 1'b0;
    cmd_abort = 1'b0;
    // Synchronisers for pins
    next_r.sync1 = {preamble_quality_indicator, sync_quality_indicator,
                    carrier_sense_valid};
    next_r.sync2 = r.sync1;
    next_r.pkt1  = packet_received;
    next_r.pkt2  = r.pkt1;
    // Write channels, either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_got  = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_got  = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    // Response follows once both halves are held
    wr_go = r.aw_got && r.w_got;
    if (wr_go) begin
      next_r.aw_got = 1'b0;
      next_r.w_got  = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = RTS_RESP_OKAY;
      // Only byte lane 0 carries the fields
      case (r.aw_addr)
        RTS_OFF_PRESCALE: begin
          if (r.w_strb[0]) next_r.prescale = r.w_data[PRE_W-1:0];
        end
        RTS_OFF_COUNT: begin
          if (r.w_strb[0]) next_r.count = r.w_data[CNT_W-1:0];
        end
        RTS_OFF_STOPCFG: begin
          if (r.w_strb[0]) next_r.stopcfg = r.w_data[3:0];
        end
        RTS_OFF_STATUS: begin
          // Read only: the write is accepted and ignored
        end
        RTS_OFF_COMMAND: begin
          if (r.w_strb[0]) begin
            cmd_start = r.w_data[RTS_CMD_START];
            cmd_abort = r.w_data[RTS_CMD_ABORT];
          end
        end
        default: next_r.bresp = RTS_RESP_SLVERR;
      endcase
    end
    // Response taken by the master
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = rd_val;
      next_r.rresp  = rd_ok ? RTS_RESP_OKAY : RTS_RESP_SLVERR;
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    // Prescaled tick
    tick = (r.pre_cnt == '0);
    // Receive state machine
    case (r.state)
      RTS_IDLE: begin
        // Start enters receive; abort wins over start
        if (cmd_start && !cmd_abort) begin
          next_r.state      = RTS_RX;
          next_r.cnt        = r.count;
          next_r.pre_cnt    = r.prescale;
          next_r.frozen     = 1'b0;
          next_r.expired    = 1'b0;
          next_r.aborted    = 1'b0;
          next_r.ready_seen = 1'b0;
        end
      end
      RTS_RX: begin
        // Abort leaves receive at once, frozen or not
        if (cmd_abort) begin
          next_r.state   = RTS_IDLE;
          next_r.aborted = 1'b1;
        end else begin
          // Freeze once stop condition fires, or never-expire mode
          if (stop_cond || (masks == 3'b000 && !r.stopcfg[RTS_CFG_AND_OR])) begin
            next_r.frozen = 1'b1;
          end
          // Packet end after a freeze ends receive with data ready
          if (r.frozen && r.pkt2) begin
            next_r.state       = RTS_IDLE;
            next_r.ready_pulse = 1'b1;
            next_r.ready_seen  = 1'b1;
          end else if (!r.frozen && !stop_cond) begin
            // Timer steps only while nothing holds it
            if (tick) begin
              // Divider reached zero: one prescaled tick
              next_r.pre_cnt = r.prescale;
              if (r.cnt == '0) begin
                // Count exhausted: leave receive and drop the packet
                next_r.state         = RTS_IDLE;
                next_r.expired       = 1'b1;
                next_r.discard_pulse = 1'b1;
              end else begin
                next_r.cnt = r.cnt - 1'b1;
              end
            end else begin
              // Divider counts down toward the next tick
              next_r.pre_cnt = r.pre_cnt - 1'b1;
            end
          end
        end
      end
      default: next_r.state = RTS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, synchronous reset
  // Reset loads the register defaults; everything else clears to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r         <= '0;
      r.state   <= RTS_IDLE;
      r.prescale <= RTS_RST_PRESCALE[PRE_W-1:0];
      r.count   <= RTS_RST_COUNT[CNT_W-1:0];
      r.stopcfg <= RTS_RST_STOPCFG;
    end else begin
      r <= next_r;
    end
  end
endmodule // rts_rx_timeout_supervisor

// ===== core/rts_pkg.sv
package rts_pkg;
  // Register byte offsets
  localparam logic [7:0] RTS_OFF_PRESCALE = 8'h00;  // Prescale value
  localparam logic [7:0] RTS_OFF_COUNT    = 8'h04;  // Count value
  localparam logic [7:0] RTS_OFF_STOPCFG  = 8'h08;  // Stop condition config
  localparam logic [7:0] RTS_OFF_STATUS   = 8'h0C;  // Status, read only
  localparam logic [7:0] RTS_OFF_COMMAND  = 8'h10;  // Command, write only
  // Stop config field positions
  localparam int RTS_CFG_CS_MASK   = 0;  // Carrier sense stop mask
  localparam int RTS_CFG_SQ_MASK   = 1;  // Sync quality stop mask
  localparam int RTS_CFG_PQ_MASK   = 2;  // Preamble quality stop mask
  localparam int RTS_CFG_AND_OR    = 3;  // Combine select, 1 means OR
  // Command field positions
  localparam int RTS_CMD_START     = 0;  // Enter receive
  localparam int RTS_CMD_ABORT     = 1;  // Abort command
  // Status field positions
  localparam int RTS_ST_IN_RX      = 0;
  localparam int RTS_ST_FROZEN     = 1;
  localparam int RTS_ST_EXPIRED    = 2;
  localparam int RTS_ST_DISCARD    = 3;
  localparam int RTS_ST_READY      = 4;
  localparam int RTS_ST_ABORTED    = 5;
  // Reset values
  localparam logic [31:0] RTS_RST_PRESCALE = 32'h0000_0000;
  localparam logic [31:0] RTS_RST_COUNT    = 32'h0000_0000;
  localparam logic [3:0]  RTS_RST_STOPCFG  = 4'h8;  // OR, no masks
  // AXI responses
  localparam logic [1:0] RTS_RESP_OKAY   = 2'b00;
  localparam logic [1:0] RTS_RESP_SLVERR = 2'b10;
  // Receive state machine
  typedef enum logic [1:0] {RTS_IDLE, RTS_RX} rts_state_t;
endpackage

// ===== sim/rts_rx_checker.sv
`timescale 1ns/10ps
// Handshake and receive outcome watch at the block ports
module rts_rx_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_active,
  input wire logic rx_data_ready,
  input wire logic packet_discard
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("bvalid kept");
  property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_once: assert property (p_r_once) else $error("rvalid kept");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_refuse: assert property (p_refuse) else $error("write taken early");
  property p_exp_exit; packet_discard |-> ##[0:1] !rx_active; endproperty
  a_exp_exit: assert property (p_exp_exit) else $error("stayed after expiry");
  property p_rdy_exit; rx_data_ready |-> ##[0:1] !rx_active; endproperty
  a_rdy_exit: assert property (p_rdy_exit) else $error("stayed after ready");
  property p_exp_pulse; packet_discard |=> !packet_discard; endproperty
  a_exp_pulse: assert property (p_exp_pulse) else $error("discard held");
  property p_excl; !(rx_data_ready && packet_discard); endproperty
  a_excl: assert property (p_excl) else $error("ready with discard");
  property p_rdy_src; rx_data_ready |-> $past(rx_active); endproperty
  a_rdy_src: assert property (p_rdy_src) else $error("ready outside receive");
  property p_exp_src; packet_discard |-> $past(rx_active); endproperty
  a_exp_src: assert property (p_exp_src) else $error("discard outside receive");
  c_exp: cover property (packet_discard);
  c_rdy: cover property (rx_data_ready);
  c_abort: cover property ($fell(rx_active) && !packet_discard && !rx_data_ready);
endmodule // rts_rx_checker
bind rts_rx_timeout_supervisor rts_rx_checker u_chk (
  .aclk           (aclk),
  .aresetn        (aresetn),
  .s_axi_awready  (s_axi_awready),
  .s_axi_wready   (s_axi_wready),
  .s_axi_bvalid   (s_axi_bvalid),
  .s_axi_bready   (s_axi_bready),
  .s_axi_arvalid  (s_axi_arvalid),
  .s_axi_arready  (s_axi_arready),
  .s_axi_rvalid   (s_axi_rvalid),
  .s_axi_rready   (s_axi_rready),
  .rx_active      (rx_active),
  .rx_data_ready  (rx_data_ready),
  .packet_discard (packet_discard)
);

// ===== sim/rx_timeout_supervisor_tb.sv
`timescale 1ns/10ps
// Bus-driven bench; a small model predicts each receive outcome
module rx_timeout_supervisor_tb;
  import rts_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, packet_received, rx_active, rx_data_ready, packet_discard;
  logic        carrier_sense_valid, sync_quality_indicator, preamble_quality_indicator;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rrs;
  int          bad_count, num_checks, seed, t, res, pre, cnt, e;
  int          exq[$];  // Predicted outcomes, oldest first
  rts_rx_timeout_supervisor u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .carrier_sense_valid(carrier_sense_valid),
    .sync_quality_indicator(sync_quality_indicator),
    .preamble_quality_indicator(preamble_quality_indicator),
    .packet_received(packet_received), .rx_active(rx_active),
    .rx_data_ready(rx_data_ready), .packet_discard(packet_discard)
  );
  // Bus clock, 50 ns period
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // One counted comparison
  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) bad_count++;
    if (got !== ex) $display("[FAIL] %s expected %h seen %h", nm, ex, got);
  endtask
  // Counts, verdict, end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // A wait that ran out ends the run
  task automatic give_up(input string nm);
    check(nm, 1'b1, 1'b0);
    conclude();
  endtask
  // One write (w=1) or read; each channel dropped once taken
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    do begin
      @(posedge aclk);
      k++;
      if ((s_axi_awvalid & s_axi_awready) === 1'b1) s_axi_awvalid <= 1'b0;
      if ((s_axi_wvalid & s_axi_wready) === 1'b1) s_axi_wvalid <= 1'b0;
      if ((s_axi_arvalid & s_axi_arready) === 1'b1) s_axi_arvalid <= 1'b0;
    end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && k < 50);
    rdv = s_axi_rdata;
    rrs = w ? s_axi_bresp : s_axi_rresp;
    if (k >= 50) give_up("bus wait");
  endtask
  // Outcome of a receive: 1 ready, 2 discard, 3 quiet exit
  task automatic watch(input int lim);
    t = 0;
    res = 0;
    while (res == 0 && t < lim) begin
      @(posedge aclk);
      t++;
      res = rx_data_ready === 1'b1 ? 1 : packet_discard === 1'b1 ? 2 : rx_active !== 1'b1 ? 3 : 0;
    end
    if (res == 0) give_up("outcome wait");
  endtask
  // Reference freeze prediction: select in bit 3, masks in bits 2:0; AND select with no mask freezes
  function automatic int stops(int c, int d);
    if ((c & 7) == 0) return c < 8;
    return (c >= 8) ? ((c & d & 7) != 0) : ((c & d & 7) == (c & 7));
  endfunction
  // Main sequence
  initial begin
    seed = 32'h885f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, packet_received, aresetn} <= 5'h00;
    {carrier_sense_valid, sync_quality_indicator, preamble_quality_indicator} <= 3'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} <= 6'h3f;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0000_0000_0000;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    bus(1'b0, RTS_OFF_STOPCFG, 32'h0000_0000);
    check("stop config", 32'h0000_0008, rdv);
    // Byte lane 0 off: the write is answered but ignored
    s_axi_wstrb <= 4'he;
    bus(1'b1, RTS_OFF_STOPCFG, 32'h0000_0007);
    check("write resp", {30'h0, RTS_RESP_OKAY}, {30'h0, rrs});
    s_axi_wstrb <= 4'hf;
    bus(1'b0, RTS_OFF_STOPCFG, 32'h0000_0000);
    check("masked write", 32'h0000_0008, rdv);
    bus(1'b1, 8'h14, 32'h0000_0001);
    check("unmapped wr resp", {30'h0, RTS_RESP_SLVERR}, {30'h0, rrs});
    // Start together with abort: abort wins, receive is not entered
    bus(1'b1, RTS_OFF_COMMAND, 32'h0000_0003);
    @(posedge aclk);
    check("start with abort", 1'b0, rx_active);
    bus(1'b0, 8'h14, 32'h0000_0000);
    check("unmapped resp", {30'h0, RTS_RESP_SLVERR}, {30'h0, rrs});
    check("unmapped data", 32'h0000_0000, rdv);
    // Default mode runs out even with every indicator live
    {carrier_sense_valid, sync_quality_indicator, preamble_quality_indicator} <= 3'h7;
    for (int i = 0; i < 3; i++) begin
      pre = $unsigned($random(seed)) % 8;
      cnt = 4 + $unsigned($random(seed)) % 16;
      e = (cnt + 1) * (pre + 1);
      bus(1'b1, RTS_OFF_PRESCALE, pre);
      bus(1'b1, RTS_OFF_COUNT, cnt);
      bus(1'b1, RTS_OFF_COMMAND, 32'h0000_0001);
      watch(400);
      check("expiry", 1'b1, res == 2 && t >= e - 3 && t <= e + 3);
    end
    bus(1'b0, RTS_OFF_STATUS, 32'h0000_0000);
    check("status expired", 32'h0000_000C, rdv);
    // Every select and mask setting against every indicator pattern
    bus(1'b1, RTS_OFF_PRESCALE, 32'h0000_0003);
    bus(1'b1, RTS_OFF_COUNT, 32'h0000_0014);
    for (int v = 0; v < 128; v++) begin
      {preamble_quality_indicator, sync_quality_indicator, carrier_sense_valid} <= v[2:0];
      bus(1'b1, RTS_OFF_STOPCFG, v >> 3);
      exq.push_back(stops(v >> 3, v & 7) ? 1 : 2);
      bus(1'b1, RTS_OFF_COMMAND, 32'h0000_0001);
      repeat (6) @(posedge aclk);
      packet_received <= 1'b1;
      watch(200);
      packet_received <= 1'b0;
      check("outcome", exq.pop_front(), res);
    end
    // Frozen timer holds receive until the abort command
    {preamble_quality_indicator, sync_quality_indicator, carrier_sense_valid} <= 3'h2;
    bus(1'b1, RTS_OFF_STOPCFG, 32'h0000_0002);
    bus(1'b1, RTS_OFF_COMMAND, 32'h0000_0001);
    repeat (200) @(posedge aclk);
    check("still receiving", 1'b1, rx_active);
    bus(1'b1, RTS_OFF_COMMAND, 32'h0000_0002);
    watch(20);
    check("abort", 3, res);
    bus(1'b0, RTS_OFF_STATUS, 32'h0000_0000);
    check("status aborted", 32'h0000_0022, rdv);
    conclude();
  end
endmodule // rx_timeout_supervisor_tb
